/* verilog/bsm_params.svh */
// constants for the boot section address map and store sequencer
`ifndef BSM_PARAMS_SVH
`define BSM_PARAMS_SVH
`define BSM_Z_W 16
`define BSM_PC_W 15
`define BSM_PAGE_W 9
`define BSM_WORD_W 7
`define BSM_CMD_W 5
// command patterns in the low five control bits
`define BSM_CMD_READEN 5'h11
`define BSM_CMD_WRITE 5'h05
`define BSM_CMD_ERASE 5'h03
`define BSM_CMD_FILL 5'h01
`define BSM_CMD_LOCK 5'h09
// arm window of the store enable bit
`define BSM_ARM_CYCLES 3'h4
// small variant: 13-bit counter, 64-word pages, 128 pages
`define BSM_S_PC_TOP 4'hC
`define BSM_S_PG_TOP 4'h5
`define BSM_S_HALT_START 15'h1C00
`define BSM_S_BOOT_11 15'h1F80
`define BSM_S_BOOT_10 15'h1F00
`define BSM_S_BOOT_01 15'h1E00
`define BSM_S_BOOT_00 15'h1C00
`define BSM_S_SIZE_11 13'h0080
`define BSM_S_PAGES_11 6'h02
// large variants: 14/15-bit counter, 64/128-word pages
`define BSM_L_PC_TOP_A 4'hD
`define BSM_L_PC_TOP_B 4'hE
`define BSM_L_PG_TOP_A 4'h5
`define BSM_L_PG_TOP_B 4'h6
`define BSM_L_HALT_A 15'h3800
`define BSM_L_HALT_B 15'h7000
`define BSM_L_TOP_A 15'h3FFF
`define BSM_L_TOP_B 15'h7FFF
`define BSM_L_SIZE_11_A 13'h0100
`define BSM_L_SIZE_11_B 13'h0200
`define BSM_L_PAGES_11 6'h04
// erase/write busy time, shortened by parameter in simulation
`define BSM_PROG_CYCLES 370000
`endif

/* verilog/bsm_pkg.sv */
// types for the boot section address map and store sequencer
package bsm_pkg;
  typedef enum logic [1:0] {
    BSM_SMALL,
    BSM_LARGE_A,
    BSM_LARGE_B
  } bsm_variant_e;
  typedef enum logic [1:0] {
    BSM_IDLE,
    BSM_ARMED,
    BSM_BUSY
  } bsm_state_e;
endpackage

/* verilog/bsm_boot_map.sv */
// boot section address map, pointer decode and store command sequencer
`timescale 1ns/1ps
`include "bsm_params.svh"
module bsm_boot_map
  import bsm_pkg::*;
#(
  parameter bsm_variant_e VARIANT = BSM_SMALL,
  parameter int PROG_CYCLES = `BSM_PROG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fuses
  input wire logic boot_size_fuse_hi,
  input wire logic boot_size_fuse_lo,
  // control register write and store instruction
  input wire logic ctrl_wr,
  input wire logic [`BSM_CMD_W-1:0] ctrl_wdata,
  input wire logic store_exec,
  input wire logic [`BSM_Z_W-1:0] z_ptr,
  // status
  output logic store_enable_bit,
  output logic concurrent_busy_flag,
  output logic [`BSM_CMD_W-1:0] active_cmd,
  // decoded map
  output logic [`BSM_PC_W-1:0] boot_start,
  output logic [`BSM_PC_W-1:0] app_end,
  output logic [12:0] boot_words,
  output logic [5:0] boot_pages,
  output logic [`BSM_PC_W-1:0] halt_start,
  // pointer fields of the last accepted store, and a one-cycle pulse for each store
  output logic [`BSM_PAGE_W-1:0] page_select_field,
  output logic [`BSM_WORD_W-1:0] word_select_field,
  output logic target_halting,
  output logic op_pulse
);
  import bsm_pkg::*;

  // ----------------------------------------------------------------
  // static map decode
  // ----------------------------------------------------------------
  localparam bit SMALL = (VARIANT == BSM_SMALL);
  localparam bit BIGB = (VARIANT == BSM_LARGE_B);
  localparam logic [3:0] PC_TOP = SMALL ? `BSM_S_PC_TOP :
    (BIGB ? `BSM_L_PC_TOP_B : `BSM_L_PC_TOP_A);
  localparam logic [3:0] PG_TOP = SMALL ? `BSM_S_PG_TOP :
    (BIGB ? `BSM_L_PG_TOP_B : `BSM_L_PG_TOP_A);
  localparam logic [`BSM_PC_W-1:0] HALT = SMALL ? `BSM_S_HALT_START :
    (BIGB ? `BSM_L_HALT_B : `BSM_L_HALT_A);
  localparam logic [`BSM_PC_W-1:0] TOPW = SMALL ? `BSM_S_BOOT_11 :
    (BIGB ? `BSM_L_TOP_B : `BSM_L_TOP_A);
  localparam logic [12:0] SIZE11 = SMALL ? `BSM_S_SIZE_11 :
    (BIGB ? `BSM_L_SIZE_11_B : `BSM_L_SIZE_11_A);
  localparam logic [5:0] PAGES11 = SMALL ? `BSM_S_PAGES_11 :
    `BSM_L_PAGES_11;

  // each step down in the fuse pair value doubles the boot size
  wire [1:0] fuse_pair = {boot_size_fuse_hi, boot_size_fuse_lo};
  wire [1:0] dbl = 2'h3 - fuse_pair;
  wire [12:0] next_words = SIZE11 << dbl;
  wire [5:0] next_pages = PAGES11 << dbl;
  // large-variant top word is all ones, so start is top + 1 - size
  wire [`BSM_PC_W-1:0] end_plus = SMALL ? (TOPW + {2'h0, SIZE11}) :
    (TOPW + 15'h0001);
  wire [`BSM_PC_W-1:0] next_start = end_plus - {2'h0, next_words};
  wire [`BSM_PC_W-1:0] next_app_end = next_start - 15'h0001;

  // ----------------------------------------------------------------
  // pointer decode
  // ----------------------------------------------------------------
  // z0 is dropped and bits above the counter top are ignored
  wire [`BSM_PC_W-1:0] pc_mask = (15'h0002 << PC_TOP) - 15'h0001;
  wire [`BSM_PC_W-1:0] z_pc = z_ptr[`BSM_Z_W-1:1] & pc_mask;
  wire [`BSM_PC_W-1:0] z_page = z_pc >> (PG_TOP + 4'h1);
  wire [`BSM_PC_W-1:0] wmask = (15'h0002 << PG_TOP) - 15'h0001;
  wire [`BSM_PC_W-1:0] z_word = z_pc & wmask;
  wire z_halting = (z_pc >= HALT);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  bsm_state_e state;
  logic [2:0] arm_cnt;
  logic [31:0] busy_cnt;

  wire cmd_ok = (ctrl_wdata == `BSM_CMD_READEN) ||
    (ctrl_wdata == `BSM_CMD_LOCK) || (ctrl_wdata == `BSM_CMD_WRITE) ||
    (ctrl_wdata == `BSM_CMD_ERASE) || (ctrl_wdata == `BSM_CMD_FILL);
  wire accept_wr = ctrl_wr && cmd_ok && (state == BSM_IDLE);
  wire fire = (state == BSM_ARMED) && store_exec;
  wire is_prog = (active_cmd == `BSM_CMD_WRITE) ||
    (active_cmd == `BSM_CMD_ERASE);
  wire timeout = (state == BSM_ARMED) && !store_exec &&
    (arm_cnt == `BSM_ARM_CYCLES - 3'h1);
  wire busy_done = (state == BSM_BUSY) &&
    (busy_cnt == PROG_CYCLES - 1);
  wire set_busy = fire && is_prog && !z_halting;
  // read enable or fill clears the busy flag only once nothing is programming
  wire clr_busy = fire && ((active_cmd == `BSM_CMD_READEN) ||
    (active_cmd == `BSM_CMD_FILL));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= BSM_IDLE;
      arm_cnt <= 3'h0;
      busy_cnt <= 32'h0;
      active_cmd <= 5'h00;
    end else begin
      case (state)
        BSM_IDLE: begin
          arm_cnt <= 3'h0;
          if (accept_wr) begin
            state <= BSM_ARMED;
            active_cmd <= ctrl_wdata;
          end
        end
        BSM_ARMED: begin
          arm_cnt <= arm_cnt + 3'h1;
          busy_cnt <= 32'h0;
          if (fire && is_prog) begin
            state <= BSM_BUSY;
          end else if (fire || timeout) begin
            state <= BSM_IDLE;
            active_cmd <= 5'h00;
          end
        end
        BSM_BUSY: begin
          busy_cnt <= busy_cnt + 32'h1;
          if (busy_done) begin
            state <= BSM_IDLE;
            active_cmd <= 5'h00;
          end
        end
        default: state <= BSM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_enable_bit <= 1'b0;
      concurrent_busy_flag <= 1'b0;
      page_select_field <= 9'h000;
      word_select_field <= 7'h00;
      target_halting <= 1'b0;
      op_pulse <= 1'b0;
      boot_start <= 15'h0000;
      app_end <= 15'h0000;
      boot_words <= 13'h0000;
      boot_pages <= 6'h00;
      halt_start <= 15'h0000;
    end else begin
      store_enable_bit <= accept_wr || (state == BSM_ARMED && !fire &&
        !timeout) || (fire && is_prog) ||
        (state == BSM_BUSY && !busy_done);
      if (set_busy) begin
        concurrent_busy_flag <= 1'b1;
      end else if (clr_busy) begin
        concurrent_busy_flag <= 1'b0;
      end
      if (fire) begin
        page_select_field <= z_page[`BSM_PAGE_W-1:0];
        word_select_field <= z_word[`BSM_WORD_W-1:0];
        target_halting <= z_halting;
      end
      op_pulse <= fire;
      boot_start <= next_start;
      app_end <= next_app_end;
      boot_words <= next_words;
      boot_pages <= next_pages;
      halt_start <= HALT;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  arm_window_a: assert property (@(posedge clk) disable iff (rst)
    $rose(state == BSM_ARMED) && !store_exec ##1 !store_exec [*3] |=>
    state == BSM_IDLE) else $error("arm window not four cycles");
  busy_set_a: assert property (@(posedge clk) disable iff (rst)
    set_busy |=> concurrent_busy_flag)
    else $error("busy flag not set by program to concurrent");
  bad_cmd_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && !cmd_ok && state == BSM_IDLE |=> state == BSM_IDLE)
    else $error("illegal command accepted");
  // map registers hold reset zeros until one edge after release
  app_end_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> app_end == boot_start - 15'h0001)
    else $error("application end not below boot start");
  spm_high_a: assert property (@(posedge clk) disable iff (rst)
    state == BSM_BUSY |=> store_enable_bit || $past(busy_done))
    else $error("store enable dropped while busy");
  page_map_a: assert property (@(posedge clk) disable iff (rst)
    fire |=> page_select_field == $past(z_page[`BSM_PAGE_W-1:0]) &&
    word_select_field == $past(z_word[`BSM_WORD_W-1:0]))
    else $error("pointer fields mis-captured");
  boot_top_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> boot_start + {2'h0, boot_words} == end_plus)
    else $error("boot section does not end at top");
  halt_cut_a: assert property (@(posedge clk) disable iff (rst)
    fire && z_pc < HALT |=> !target_halting)
    else $error("concurrent address flagged halting");
endmodule // bsm_boot_map

/* verif/bsm_fw_model.sv */
// boot loader firmware model driving the store sequencer
`timescale 1ns/1ps
module bsm_fw_model (
  // clock
  input wire logic clk,
  // status seen by firmware
  input wire logic store_enable_bit,
  input wire logic concurrent_busy_flag,
  input wire logic eeprom_write_enable_bit,
  // command write and store instruction
  output logic ctrl_wr,
  output logic [4:0] ctrl_wdata,
  output logic store_exec,
  output logic [15:0] z_ptr
);
  logic irq_en = 1'b1;
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 5'h00;
    store_exec = 1'b0;
    z_ptr = 16'h0000;
  end
  // ---------------------------------------------------------------
  // firmware steps
  // ---------------------------------------------------------------
  task automatic settle(output bit ok);
    int n;
    n = 0;
    while (store_enable_bit !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    while (eeprom_write_enable_bit !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 200);
  endtask
  task automatic raw_wr(input logic [4:0] c);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= c;
    @(posedge clk);
    ctrl_wr <= 1'b0;
  endtask
  task automatic run(input logic [4:0] c, input logic [15:0] z,
                     output bit ok);
    logic saved;
    settle(ok);
    saved = irq_en;
    irq_en = 1'b0;
    raw_wr(c);
    irq_en = saved;
    @(posedge clk);
    store_exec <= 1'b1;
    z_ptr <= {z[15:1], 1'b0};
    @(posedge clk);
    store_exec <= 1'b0;
  endtask
  // busy may still be up: keep asking until the section reopens
  task automatic reopen(output bit ok);
    ok = 1'b0;
    for (int k = 0; k < 8 && !ok; k++) begin
      run(5'h11, 16'h0000, ok);
      @(posedge clk);
      ok = ok && (concurrent_busy_flag === 1'b0);
    end
  endtask
endmodule // bsm_fw_model

/* verif/tb_top.sv */
// self-checking bench for the boot map and store sequencer
`timescale 1ns/1ps
module tb_top;
  import bsm_pkg::*;
  logic clk, rst, fhi, flo, wr, sx, se, busy, tgt, opp, ee;
  logic [4:0] wdat, acmd;
  logic [15:0] z, w;
  logic [14:0] bstart, aend, hstart;
  logic [12:0] bwords;
  logic [5:0] bpages;
  logic [8:0] pg;
  logic [6:0] wd;
  logic busy_b, tgt_b;
  logic [14:0] bstart_b, aend_b, hstart_b;
  logic [12:0] bwords_b;
  logic [5:0] bpages_b;
  logic [8:0] pg_b;
  logic [6:0] wd_b;
  logic [4:0] codes [8] = '{5'h11, 5'h09, 5'h05, 5'h01, 5'h03,
                            5'h02, 5'h1F, 5'h13};
  int n_errors = 0;
  int check_count = 0;
  bit ok;
  bsm_boot_map #(.VARIANT(BSM_SMALL), .PROG_CYCLES(20)) uut (
    .clk(clk), .rst(rst), .boot_size_fuse_hi(fhi),
    .boot_size_fuse_lo(flo), .ctrl_wr(wr), .ctrl_wdata(wdat),
    .store_exec(sx), .z_ptr(z), .store_enable_bit(se),
    .concurrent_busy_flag(busy), .active_cmd(acmd),
    .boot_start(bstart), .app_end(aend), .boot_words(bwords),
    .boot_pages(bpages), .halt_start(hstart), .page_select_field(pg),
    .word_select_field(wd), .target_halting(tgt), .op_pulse(opp));
  // large variant on the same stimulus, to reach the wide decode
  bsm_boot_map #(.VARIANT(BSM_LARGE_B), .PROG_CYCLES(20)) uut_big (
    .clk(clk), .rst(rst), .boot_size_fuse_hi(fhi),
    .boot_size_fuse_lo(flo), .ctrl_wr(wr), .ctrl_wdata(wdat),
    .store_exec(sx), .z_ptr(z), .store_enable_bit(),
    .concurrent_busy_flag(busy_b), .active_cmd(),
    .boot_start(bstart_b), .app_end(aend_b), .boot_words(bwords_b),
    .boot_pages(bpages_b), .halt_start(hstart_b),
    .page_select_field(pg_b), .word_select_field(wd_b),
    .target_halting(tgt_b), .op_pulse());
  bsm_fw_model fw (
    .clk(clk), .store_enable_bit(se), .concurrent_busy_flag(busy),
    .eeprom_write_enable_bit(ee), .ctrl_wr(wr), .ctrl_wdata(wdat),
    .store_exec(sx), .z_ptr(z));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic need(input bit k);
    if (!k) begin
      n_errors++;
      $display("BAD wait exp done got timeout");
      complete_run();
    end
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    fhi = 1'b1;
    flo = 1'b1;
    ee = 1'b0;
    void'($urandom(72));
    for (int f = 3; f >= 0; f--) begin
      @(posedge clk);
      fhi <= f[1];
      flo <= f[0];
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      w = 16'h0080 << (3 - f);
      chk("boot_words", bwords, w);
      chk("boot_pages", bpages, w >> 6);
      chk("boot_start", bstart, 16'h2000 - w);
      chk("app_end", aend, 16'h1FFF - w);
      chk("halt_start", hstart, 16'h1C00);
      chk("boot_words_b", bwords_b, w << 2);
      chk("boot_pages_b", bpages_b, w >> 5);
      chk("boot_start_b", bstart_b, 16'h8000 - (w << 2));
      chk("app_end_b", aend_b, 16'h7FFF - (w << 2));
      chk("halt_start_b", hstart_b, 16'h7000);
      $display("test fuse %0d done", f);
    end
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      fw.run(5'h01, w, ok);
      need(ok);
      #1;
      chk("word_sel", wd, w[6:1]);
      chk("page_sel", pg, w[13:7]);
      chk("word_sel_b", wd_b, w[7:1]);
      chk("page_sel_b", pg_b, w[15:8]);
      chk("op_pulse", opp, 1'b1);
      @(posedge clk);
      #1;
      chk("op_pulse", opp, 1'b0);
    end
    $display("test fill done");
    // last concurrent page, top pointer bits set
    fw.run(5'h03, 16'hF780, ok);
    need(ok);
    #1;
    chk("busy", busy, 1'b1);
    chk("halting", tgt, 1'b0);
    chk("page_sel", pg, 9'h06F);
    chk("halting_b", tgt_b, 1'b1);
    repeat (5) @(posedge clk);
    #1;
    chk("store_en", se, 1'b1);
    chk("active_cmd", acmd, 5'h03);
    fw.reopen(ok);
    need(ok);
    #1;
    chk("busy", busy, 1'b0);
    $display("test erase done");
    // first halting page
    fw.run(5'h05, 16'h3800, ok);
    need(ok);
    #1;
    chk("busy", busy, 1'b0);
    chk("halting", tgt, 1'b1);
    chk("store_en", se, 1'b1);
    chk("busy_b", busy_b, 1'b1);
    chk("halting_b", tgt_b, 1'b0);
    $display("test write done");
    foreach (codes[j]) begin
      fw.settle(ok);
      need(ok);
      fw.raw_wr(codes[j]);
      #1;
      chk("armed", se, j < 5);
      chk("active_cmd", acmd, (j < 5) ? codes[j] : 5'h00);
      repeat (6) @(posedge clk);
      #1;
      chk("arm_expire", se, 1'b0);
      chk("cmd_clear", acmd, 5'h00);
    end
    $display("test patterns done");
    complete_run();
  end
endmodule // tb_top
